// ### rtl/tcs_map.svh
// Register offsets, field positions, reset values and codes of the timer control core
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

// Global register byte addresses
`define TCS_ADR_START      8'h00
`define TCS_ADR_SYNC       8'h04
// Per-channel window: base = (channel + 1) * stride
`define TCS_CH_STRIDE      8'h20
`define TCS_CH_FIRST       3'h1
`define TCS_CH_LAST        3'h6
// Offsets inside a channel window
`define TCS_OFF_CNT        5'h00
`define TCS_OFF_GA         5'h04
`define TCS_OFF_GB         5'h08
`define TCS_OFF_GC         5'h0c
`define TCS_OFF_GD         5'h10
`define TCS_OFF_STAT       5'h14

// Field layout
`define TCS_CH_BITS        6
`define TCS_CH_MSB         5
`define TCS_RSV_MSB        7
`define TCS_RSV_LSB        6
`define TCS_STAT_OVF       4
`define TCS_STAT_W         5
`define TCS_CLR_W          3
`define TCS_ACT_W          2

// Reset values
`define TCS_START_RST      6'h00
`define TCS_SYNC_RST       6'h00
`define TCS_CNT_RST        16'h0000
`define TCS_CNT_MAX        16'hffff
`define TCS_GREG_RST       16'hffff
`define TCS_FLAG_RST       5'h00

// Counter clear sources
`define TCS_CLR_NONE       3'h0
`define TCS_CLR_A          3'h1
`define TCS_CLR_B          3'h2
`define TCS_CLR_SYNC       3'h3
`define TCS_CLR_NONE2      3'h4
`define TCS_CLR_C          3'h5
`define TCS_CLR_D          3'h6
`define TCS_CLR_SYNC2      3'h7

// Compare output actions
`define TCS_ACT_KEEP       2'h0
`define TCS_ACT_LOW        2'h1
`define TCS_ACT_HIGH       2'h2
`define TCS_ACT_TOGGLE     2'h3

// Byte lanes for 16-bit registers
`define TCS_SEL_HALF       2'h3

`endif

// ### rtl/tcs_pkg.sv
// Shared types of the timer control core
`default_nettype none
package tcs_pkg;
  typedef logic [15:0] tcs_word_t;
  typedef logic [5:0]  tcs_chmask_t;
endpackage
`default_nettype wire

// ### rtl/tcs_channel.sv
// One timer channel: up counter, general compare/capture registers, flags, output pin
`timescale 1ns/10ps
`default_nettype none
`include "tcs_map.svh"
module tcs_channel #(
  parameter bit HAS_CD = 1'b0
) (
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic                run,
  input  wire logic                tick,
  input  wire logic [2:0]          clr_sel,
  input  wire logic                buf_mode,
  input  wire logic [3:0]          is_capture,
  input  wire logic [3:0]          capture_stb,
  input  wire logic                sync_clr,
  input  wire logic                preset_stb,
  input  wire tcs_pkg::tcs_word_t  wr_data,
  input  wire logic [3:0]          greg_wr,
  input  wire logic [4:0]          flag_clr,
  input  wire logic [7:0]          pin_act,
  input  wire logic                pin_io_wr,
  input  wire logic                pin_init,
  output tcs_pkg::tcs_word_t       cnt_o,
  output logic [63:0]              greg_o,
  output logic [4:0]               flag_o,
  output logic                     own_clr_o,
  output logic [3:0]               match_o,
  output logic                     pin_o
);
  tcs_pkg::tcs_word_t cnt_q, cnt_d;
  tcs_pkg::tcs_word_t g_q [4];
  logic [4:0]         flag_q;
  logic               pin_q, pin_d;
  logic               step, sync_sel, do_clr, ovf;
  logic [3:0]         present, match, cap, evt;

  // Registers C and D exist only on buffer-capable channels
  assign present = HAS_CD ? 4'hf : 4'h3;
  assign step    = run & tick;                                   // see R6
  // C and D act as buffers and do not compare while buffering
  assign match[0] = step & ~is_capture[0] & (cnt_q == g_q[0]);   // see R1
  assign match[1] = step & ~is_capture[1] & (cnt_q == g_q[1]);
  assign match[2] = step & present[2] & ~buf_mode & ~is_capture[2] & (cnt_q == g_q[2]);
  assign match[3] = step & present[3] & ~buf_mode & ~is_capture[3] & (cnt_q == g_q[3]);
  assign cap      = capture_stb & is_capture & present & ~{buf_mode, buf_mode, 2'b00}; // see R20
  assign evt      = match | cap;

  // Own clear event from the selected source
  assign own_clr_o = (clr_sel == `TCS_CLR_A & evt[0]) | (clr_sel == `TCS_CLR_B & evt[1])
                   | (clr_sel == `TCS_CLR_C & evt[2]) | (clr_sel == `TCS_CLR_D & evt[3]); // see R19
  assign sync_sel  = (clr_sel == `TCS_CLR_SYNC) | (clr_sel == `TCS_CLR_SYNC2);
  assign do_clr    = own_clr_o | (sync_clr & sync_sel);           // see R13
  assign ovf       = step & (cnt_q == `TCS_CNT_MAX) & ~do_clr & ~preset_stb; // see R18

  // Counter next value: preset beats clear beats count
  always_comb begin
    if (preset_stb) begin
      cnt_d = wr_data;                                           // see R13
    end else if (do_clr) begin
      cnt_d = `TCS_CNT_RST;                                      // see R19
    end else if (step) begin
      cnt_d = cnt_q + 16'h0001;                                  // see R16
    end else begin
      cnt_d = cnt_q;                                             // see R6
    end
  end

  // Pin level: an I/O control write while stopped loads the initial level
  always_comb begin
    pin_d = pin_q;
    if (pin_io_wr & ~run) begin
      pin_d = pin_init;                                          // see R8
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (match[i]) begin
          case (pin_act[2*i +: 2])
            `TCS_ACT_LOW:    pin_d = 1'b0;
            `TCS_ACT_HIGH:   pin_d = 1'b1;
            `TCS_ACT_TOGGLE: pin_d = ~pin_d;
            default:         pin_d = pin_d;
          endcase
        end
      end
    end
  end

  // Counter, flags and pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= `TCS_CNT_RST;                                    // see R17
      flag_q <= `TCS_FLAG_RST;
      pin_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      flag_q <= (flag_q & ~flag_clr) | {ovf, evt};               // see R18
      pin_q  <= pin_d;                                           // see R7
    end
  end

  // General registers: capture, buffer transfer, then software write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        g_q[i] <= `TCS_GREG_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!present[i]) begin
          g_q[i] <= `TCS_GREG_RST;                               // see R2
        end else if (i < 2 && cap[i]) begin
          g_q[i] <= cnt_q;                                       // see R1
        end else if (i < 2 && match[i] && buf_mode && HAS_CD) begin
          g_q[i] <= g_q[(i % 2) + 2];                            // see R3
        end else if (i >= 2 && buf_mode && cap[i % 2]) begin
          g_q[i] <= g_q[i % 2];                                  // see R3
        end else if (i >= 2 && cap[i]) begin
          g_q[i] <= cnt_q;
        end else if (greg_wr[i]) begin
          g_q[i] <= wr_data;
        end
      end
    end
  end

  assign cnt_o   = cnt_q;
  assign greg_o  = {g_q[3], g_q[2], g_q[1], g_q[0]};
  assign flag_o  = flag_q;
  assign match_o = match;
  assign pin_o   = pin_q;
endmodule
`default_nettype wire

// ### rtl/tcs_timer.sv
// Six-channel timer control core with a classic Wishbone register slave
//
// Behaviour
// [R1] Each general register is 16-bit, used as compare value or capture target.
// [R2] Sixteen general registers: four on channels 0 and 3, two elsewhere.
// [R3] On channels 0 and 3, C buffers A and D buffers B.
// [R4] Software accesses general registers only as whole 16-bit words.
// [R5] Start register is 8 bits; bits 5..0 run channels 5..0.
// [R6] Start bit 1 lets the counter count; 0 holds its value.
// [R7] Stopping a channel keeps its output pin at its present level.
// [R8] Pin I/O write while stopped drives the pin to its initial level.
// [R9] Software stops a counter before changing its mode or clock.
// [R10] Software writes zero to reserved bits 7 and 6; they reset zero.
// [R11] Sync register is 8 bits; bits 5..0 choose independent or synchronous.
// [R12] Sync bit 1 joins synchronous operation; 0 presets and clears alone.
// [R13] Counter write presets all synced counters; synced clears propagate on request.
// [R14] Synchronous operation needs sync bits of at least two channels set.
// [R15] Synchronous clearing also needs the sync clear source selected.
// [R16] Counters count upward: free-running, periodic or external events.
// [R17] Each counter is 16 bits and resets to zero.
// [R18] Roll-over from all ones sets the overflow flag, counting continues.
// [R19] Compare-match clearing sets the match flag and zeroes the counter.
// [R20] Compare or capture role follows the external pin I/O setting input.
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "tcs_map.svh"
module tcs_timer (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic [5:0]   count_tick,
  input  wire logic [17:0]  counter_clear_source,
  input  wire logic [1:0]   buffer_mode,
  input  wire logic [23:0]  capture_role,
  input  wire logic [23:0]  capture_strobe,
  input  wire logic [47:0]  compare_action,
  input  wire logic [5:0]   pin_io_control_wr,
  input  wire logic [5:0]   pin_io_control_init,
  output logic [5:0]        timer_channel_pin
);
  // Bus state
  logic                ack_q;
  logic [31:0]         dat_q, rd_mux;
  tcs_pkg::tcs_chmask_t run_q, sync_q;

  // Channel outputs
  tcs_pkg::tcs_word_t  cnt_w  [6];
  logic [63:0]         greg_w [6];
  logic [4:0]          flag_w [6];
  logic [5:0]          own_clr_w;
  logic [3:0]          match_w [6];

  // Address decode
  wire         req       = wb_cyc_i & wb_stb_i;
  wire         wr_go     = req & wb_we_i & ack_q;
  wire  [2:0]  ch_slot   = wb_adr_i[7:5];
  wire  [4:0]  ch_off    = wb_adr_i[4:0];
  wire         in_ch     = (ch_slot >= `TCS_CH_FIRST) & (ch_slot <= `TCS_CH_LAST);
  wire  [2:0]  ch_idx    = ch_slot - `TCS_CH_FIRST;
  wire         hit_start = (wb_adr_i == `TCS_ADR_START);
  wire         hit_sync  = (wb_adr_i == `TCS_ADR_SYNC);
  wire         half_ok   = (wb_sel_i[1:0] == `TCS_SEL_HALF);      // see R4
  wire         low_ok    = wb_sel_i[0];

  // Per-channel write strobes for the selected window
  wire         wr_ch     = wr_go & in_ch & half_ok;              // see R4
  wire         wr_cnt    = wr_ch & (ch_off == `TCS_OFF_CNT);
  wire         wr_ga     = wr_ch & (ch_off == `TCS_OFF_GA);
  wire         wr_gb     = wr_ch & (ch_off == `TCS_OFF_GB);
  wire         wr_gc     = wr_ch & (ch_off == `TCS_OFF_GC);
  wire         wr_gd     = wr_ch & (ch_off == `TCS_OFF_GD);
  wire         wr_stat   = wr_go & in_ch & low_ok & (ch_off == `TCS_OFF_STAT);
  wire  [3:0]  greg_sel  = {wr_gd, wr_gc, wr_gb, wr_ga};

  // Synchronous preset and clear distribution
  wire  [5:0]  cnt_wr_ch;
  wire         sync_wr_any;
  wire         sync_clr_any;

  // One-hot counter write per channel
  genvar gi;
  generate
    for (gi = 0; gi < `TCS_CH_BITS; gi++) begin : g_dec
      assign cnt_wr_ch[gi] = wr_cnt & (ch_idx == 3'(gi));
    end
  endgenerate

  assign sync_wr_any  = |(cnt_wr_ch & sync_q);                    // see R13
  assign sync_clr_any = |(own_clr_w & sync_q);                    // see R13

  // Channel instances; 0 and 3 carry registers C and D
  generate
    for (gi = 0; gi < `TCS_CH_BITS; gi++) begin : g_ch
      wire        mine     = (ch_idx == 3'(gi));
      wire        preset   = cnt_wr_ch[gi] | (sync_wr_any & sync_q[gi]);  // see R12
      wire        sclr     = sync_clr_any & sync_q[gi];                   // see R12
      wire [3:0]  gwr      = mine ? greg_sel : 4'h0;
      wire [4:0]  fclr     = (wr_stat & mine) ? ~wb_dat_i[4:0] : 5'h00;
      wire        bmode    = (gi == 0) ? buffer_mode[0] : (gi == 3) ? buffer_mode[1] : 1'b0;
      tcs_channel #(
        .HAS_CD      ((gi == 0) || (gi == 3))                     // see R2
      ) u_ch (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .run         (run_q[gi]),                                 // see R6
        .tick        (count_tick[gi]),                            // see R16
        .clr_sel     (counter_clear_source[3*gi +: 3]),
        .buf_mode    (bmode),                                     // see R3
        .is_capture  (capture_role[4*gi +: 4]),                   // see R20
        .capture_stb (capture_strobe[4*gi +: 4]),
        .sync_clr    (sclr),
        .preset_stb  (preset),
        .wr_data     (wb_dat_i[15:0]),
        .greg_wr     (gwr),
        .flag_clr    (fclr),
        .pin_act     (compare_action[8*gi +: 8]),
        .pin_io_wr   (pin_io_control_wr[gi]),
        .pin_init    (pin_io_control_init[gi]),
        .cnt_o       (cnt_w[gi]),
        .greg_o      (greg_w[gi]),
        .flag_o      (flag_w[gi]),
        .own_clr_o   (own_clr_w[gi]),
        .match_o     (match_w[gi]),
        .pin_o       (timer_channel_pin[gi])
      );
    end
  endgenerate

  // Read data selection; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_start) begin
      rd_mux[`TCS_CH_MSB:0] = run_q;                              // see R5
    end else if (hit_sync) begin
      rd_mux[`TCS_CH_MSB:0] = sync_q;                             // see R11
    end else if (in_ch && ch_idx < 3'h6) begin
      case (ch_off)
        `TCS_OFF_CNT:  rd_mux[15:0] = cnt_w[ch_idx];
        `TCS_OFF_GA:   rd_mux[15:0] = greg_w[ch_idx][15:0];
        `TCS_OFF_GB:   rd_mux[15:0] = greg_w[ch_idx][31:16];
        `TCS_OFF_GC:   rd_mux[15:0] = greg_w[ch_idx][47:32];
        `TCS_OFF_GD:   rd_mux[15:0] = greg_w[ch_idx][63:48];
        `TCS_OFF_STAT: rd_mux[`TCS_STAT_W-1:0] = flag_w[ch_idx];
        default:       rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Wishbone answer: ack one cycle after the request, dropped after one cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      dat_q <= rd_mux;
    end
  end

  // Start and sync registers; reserved bits are not stored and read zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q  <= `TCS_START_RST;                                   // see R10
      sync_q <= `TCS_SYNC_RST;                                    // see R10
    end else begin
      if (wr_go && hit_start && low_ok) begin
        run_q <= wb_dat_i[`TCS_CH_MSB:0];                         // see R5
      end
      if (wr_go && hit_sync && low_ok) begin
        sync_q <= wb_dat_i[`TCS_CH_MSB:0];                        // see R11
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Checks on the bus slave and channel 0, 1 and 2 behaviour
  AST_ACK_NEXT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (req && !ack_q) |=> (ack_q ##1 !ack_q))
    else $error("ack did not answer one cycle after request");

  AST_START_RSV_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R10
    (ack_q && !wb_we_i && $past(hit_start) && hit_start) |-> (wb_dat_o[31:6] == 26'h0))
    else $error("start register reserved bits not zero");

  AST_START_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R5
    (wr_go && hit_start && low_ok) |=> (run_q == $past(wb_dat_i[5:0])))
    else $error("start register write lost");

  AST_HOLD_STOPPED: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R6
    (!run_q[0] && !cnt_wr_ch[0] && !(sync_wr_any && sync_q[0]) && !own_clr_w[0]
     && !(sync_clr_any && sync_q[0])) |=> (cnt_w[0] == $past(cnt_w[0])))
    else $error("stopped counter changed");

  AST_COUNT_UP: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R16
    (run_q[0] && count_tick[0] && counter_clear_source[2:0] == `TCS_CLR_NONE && !wr_go)
    |=> (cnt_w[0] == $past(cnt_w[0]) + 16'h0001))
    else $error("running counter did not step by one");

  AST_OVERFLOW: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R18
    (run_q[0] && count_tick[0] && cnt_w[0] == `TCS_CNT_MAX
     && counter_clear_source[2:0] == `TCS_CLR_NONE && !wr_go)
    |=> (cnt_w[0] == `TCS_CNT_RST && flag_w[0][`TCS_STAT_OVF]))
    else $error("overflow not flagged or counter not wrapped");

  AST_MATCH_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R19
    (match_w[1][0] && counter_clear_source[5:3] == `TCS_CLR_A && !wr_go)
    |=> (cnt_w[1] == `TCS_CNT_RST && flag_w[1][0]))
    else $error("compare match did not clear counter and set flag");

  AST_SYNC_PRESET: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R13
    (cnt_wr_ch[0] && sync_q[0] && sync_q[2]) |=> (cnt_w[2] == $past(wb_dat_i[15:0])))
    else $error("synchronous preset missed a member");

  AST_INDEP_PRESET: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R12
    (cnt_wr_ch[0] && !sync_q[1] && !run_q[1] && !own_clr_w[1])
    |=> (cnt_w[1] == $past(cnt_w[1])))
    else $error("independent counter followed a foreign preset");

  AST_PIN_INIT: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R8
    (pin_io_control_wr[1] && !run_q[1]) |=> (timer_channel_pin[1] == $past(pin_io_control_init[1])))
    else $error("pin not driven to initial level");

  AST_PIN_KEEP: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R7
    (!run_q[1] && !pin_io_control_wr[1]) |=> $stable(timer_channel_pin[1]))
    else $error("stopped channel changed its pin");

  AST_HALF_ONLY: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R4
    (wr_go && in_ch && ch_idx == 3'h2 && ch_off == `TCS_OFF_GA && !half_ok && !capture_strobe[8])
    |=> (greg_w[2][15:0] == $past(greg_w[2][15:0])))
    else $error("byte write reached a general register");
endmodule
`default_nettype wire

// ### tb/tcs_timer_tb.sv
// Self-checking testbench of the six-channel timer control core
`timescale 1ns/10ps
`default_nettype none
`include "tcs_map.svh"
module tcs_timer_tb;
  localparam int LIMIT = 20000;
  logic        ref_clk      = 1'b0;
  logic        arst_n       = 1'b0;
  logic        wb_cyc       = 1'b0;
  logic        wb_stb       = 1'b0;
  logic        wb_we        = 1'b0;
  logic [7:0]  wb_adr       = 8'h00;
  logic [3:0]  wb_sel       = 4'h0;
  logic [31:0] wb_dat       = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [5:0]  tick         = 6'h3f;
  logic [17:0] clr_src      = 18'h0;
  logic [1:0]  buf_mode     = 2'h0;
  logic [23:0] cap_role     = 24'h0;
  logic [23:0] cap_stb      = 24'h0;
  logic [47:0] cmp_act      = 48'h0;
  logic [5:0]  pin_wr       = 6'h0;
  logic [5:0]  pin_init     = 6'h0;
  logic [5:0]  pin;
  logic [31:0] q;
  logic [31:0] p;
  int          errors       = 0;
  int          n_checks     = 0;
  int          cyc_cnt      = 0;

  tcs_timer dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .count_tick(tick),
    .counter_clear_source(clr_src), .buffer_mode(buf_mode), .capture_role(cap_role),
    .capture_strobe(cap_stb), .compare_action(cmp_act), .pin_io_control_wr(pin_wr),
    .pin_io_control_init(pin_init), .timer_channel_pin(pin)
  );

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  // Byte address of a register inside a channel window
  function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
    return 8'((ch + 1) * 32) + {3'h0, off};
  endfunction

  // Classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat <= d;
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hf, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, 4'hf, r);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Compare a read or observed value against its expectation
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    chk(nm, e, r);
  endtask

  // One-cycle capture event on one register
  task automatic cap(input int b);
    @(posedge ref_clk);
    cap_stb <= 24'h1 << b;
    @(posedge ref_clk);
    cap_stb <= 24'h0;
  endtask

  // One-cycle pin setting write on one channel
  task automatic pio(input int ch);
    @(posedge ref_clk);
    pin_wr <= 6'h1 << ch;
    @(posedge ref_clk);
    pin_wr <= 6'h0;
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      errors++;
      results();
    end
  end

  // Main sequence
  initial begin
    idle(16);
    arst_n <= 1'b1;
    rchk("start_rst", `TCS_ADR_START, 32'h0);
    rchk("sync_rst", `TCS_ADR_SYNC, 32'h0);
    for (int c = 0; c < 6; c++) begin
      rchk("cnt_rst", ra(c, `TCS_OFF_CNT), 32'h0);
      rchk("ga_rst", ra(c, `TCS_OFF_GA), 32'hffff);
    end
    wr(`TCS_ADR_START, 32'h3f);
    rchk("start_rsv", `TCS_ADR_START, 32'h3f);
    wr(`TCS_ADR_SYNC, 32'h3f);
    rchk("sync_rsv", `TCS_ADR_SYNC, 32'h3f);
    wr(`TCS_ADR_START, 32'h0);
    wr(`TCS_ADR_SYNC, 32'h0);
    rchk("unmapped", 8'h08, 32'h0);
    // Every general register slot; C and D exist only on channels 0 and 3
    for (int c = 0; c < 6; c++) begin
      for (int g = 0; g < 4; g++) begin
        wr(ra(c, 5'(4 + 4 * g)), 32'h1000 + 32'(c * 16 + g));
        rchk("greg", ra(c, 5'(4 + 4 * g)), (g < 2 || c == 0 || c == 3) ?
             32'h1000 + 32'(c * 16 + g) : 32'hffff);
      end
    end
    wb(1'b1, ra(2, `TCS_OFF_GA), 32'h55, 4'h1, q);
    rchk("byte_wr", ra(2, `TCS_OFF_GA), 32'h1020);
    // Run and hold; channel 1 is zeroed after the all-channel run above
    wr(ra(1, `TCS_OFF_CNT), 32'h0);
    wr(ra(0, `TCS_OFF_CNT), 32'h0);
    wr(`TCS_ADR_START, 32'h01);
    idle(20);
    wr(`TCS_ADR_START, 32'h0);
    rd(ra(0, `TCS_OFF_CNT), p);
    chk("cnt_up", 32'h1, {31'h0, p > 32'h10 && p < 32'h30});
    idle(10);
    rchk("cnt_hold", ra(0, `TCS_OFF_CNT), p);
    rchk("cnt_other", ra(1, `TCS_OFF_CNT), 32'h0);
    // Roll-over from all ones
    wr(ra(0, `TCS_OFF_CNT), 32'hfff0);
    rchk("preset", ra(0, `TCS_OFF_CNT), 32'hfff0);
    wr(`TCS_ADR_START, 32'h01);
    idle(30);
    wr(`TCS_ADR_START, 32'h0);
    rd(ra(0, `TCS_OFF_STAT), q);
    chk("ovf", 32'h10, q & 32'h10);
    rd(ra(0, `TCS_OFF_CNT), q);
    chk("wrap", 32'h1, {31'h0, q < 32'h40});
    // Periodic count on channel 1 with period register A
    clr_src[5:3] <= `TCS_CLR_A;
    cmp_act[9:8] <= `TCS_ACT_TOGGLE;
    wr(ra(1, `TCS_OFF_GA), 32'h5);
    wr(ra(1, `TCS_OFF_CNT), 32'h0);
    wr(`TCS_ADR_START, 32'h02);
    idle(23);
    wr(`TCS_ADR_START, 32'h0);
    rd(ra(1, `TCS_OFF_CNT), q);
    chk("period", 32'h1, {31'h0, q <= 32'h5});
    rd(ra(1, `TCS_OFF_STAT), q);
    chk("match_a", 32'h1, q & 32'h1);
    wr(ra(1, `TCS_OFF_STAT), 32'h1e);
    rd(ra(1, `TCS_OFF_STAT), q);
    chk("flag_clr", 32'h0, q & 32'h1);
    // Stopped channel keeps its output, pin setting write loads initial level
    p = {26'h0, pin};
    idle(10);
    chk("pin_hold", p, {26'h0, pin});
    for (int v = 0; v < 2; v++) begin
      pin_init[1] <= v[0];
      pio(1);
      idle(2);
      chk("pin_init", 32'(v), {31'h0, pin[1]});
    end
    // Synchronous preset and clear of channels 0 and 2
    clr_src[2:0] <= `TCS_CLR_A;
    clr_src[8:6] <= `TCS_CLR_SYNC;
    wr(ra(0, `TCS_OFF_GA), 32'h3);
    wr(ra(1, `TCS_OFF_CNT), 32'h0);
    wr(`TCS_ADR_SYNC, 32'h05);
    wr(ra(0, `TCS_OFF_CNT), 32'h1);
    rchk("sync_pre", ra(2, `TCS_OFF_CNT), 32'h1);
    rchk("indep", ra(1, `TCS_OFF_CNT), 32'h0);
    wr(`TCS_ADR_START, 32'h05);
    idle(27);
    wr(`TCS_ADR_START, 32'h0);
    rd(ra(0, `TCS_OFF_CNT), p);
    rchk("sync_clr", ra(2, `TCS_OFF_CNT), p);
    chk("sync_le", 32'h1, {31'h0, p <= 32'h3});
    wr(`TCS_ADR_SYNC, 32'h0);
    // Capture role follows the pin setting input
    cap_role[16] <= 1'b1;
    wr(ra(4, `TCS_OFF_CNT), 32'h42);
    cap(16);
    rchk("capture", ra(4, `TCS_OFF_GA), 32'h42);
    cap(17);
    rchk("no_cap", ra(4, `TCS_OFF_GB), 32'h1041);
    // Buffered capture on channel 3: old A moves to C
    buf_mode <= 2'h2;
    cap_role[12] <= 1'b1;
    wr(ra(3, `TCS_OFF_CNT), 32'h7);
    cap(12);
    rchk("buf_a", ra(3, `TCS_OFF_GA), 32'h7);
    rchk("buf_c", ra(3, `TCS_OFF_GC), 32'h1030);
    wr(ra(3, `TCS_OFF_CNT), 32'h9);
    cap(12);
    rchk("buf_a2", ra(3, `TCS_OFF_GA), 32'h9);
    rchk("buf_c2", ra(3, `TCS_OFF_GC), 32'h7);
    results();
  end
endmodule
`default_nettype wire
